// file: logic/tct_trim_ctrl.sv
/*
  trim and temperature-compensation control: registers, snapshot of the
  settings, cycle scheduling and the final trim outputs.
  assumes the sensor converter answers a start pulse with a done level
  and a stable signed temperature in degrees celsius.
*/
`timescale 1ns/10ps

module tct_trim_ctrl #(
  parameter int P_SEC_CYCLES = tct_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // register port
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic      [7:0]        o_reg_rdata,
  // supply monitor
  input  wire logic              i_bat_mode,
  input  wire logic              i_bat_low,
  // sensor and converter
  output logic                   o_conv_start,
  input  wire logic              i_conv_done,
  input  wire logic [7:0]        i_temp,
  // oscillator trim network
  output tct_pkg::tct_final_t    o_final
);
  import tct_pkg::*;

  typedef enum logic [0:0] {S_IDLE, S_WAIT} tct_state_t;

  // correction arithmetic, replaceable as a whole
  function automatic tct_final_t calc(tct_regs_t s, logic [7:0] t);
    int         tot;
    int         dt;
    int         k;
    int         st;
    tct_final_t f;
    dt  = int'($signed(t)) - ROOM_DEGC;
    tot = ANA_MID - int'(s.trim.ana);
    tot = tot + (s.trim.dig == 2'b01 ? 32 : 0)
              - (s.trim.dig == 2'b11 ? 32 : 0);
    tot = tot + (int'(s.curv) * dt * dt) / CURV_DIV;
    k   = 0;
    if (tot < -31)
    begin
      k   = 7;
      tot = tot + 32;
    end
    for (int i = 0; i < 6; i++)
      if (tot > 32 && k < 6)
      begin
        tot = tot - 32;
        k   = k + 1;
      end
    st = (tot * 8) / int'(s.ctrl.gain);
    if (st > 32)
      st = 32;
    if (st < -31)
      st = -31;
    f.dig = k[2:0];
    f.ana = 6'(ANA_MID - st);
    return f;
  endfunction

  // initial digital code to final digital code
  function automatic logic [2:0] dig_map(logic [1:0] c);
    case (c)
      2'b01:   return 3'h1;
      2'b11:   return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  tct_regs_t   regs_r, regs_nxt, act_r, act_nxt;
  tct_final_t  fin_r, fin_nxt;
  tct_state_t  st_r, st_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        start_r, start_nxt, en_d_r;
  logic [31:0] cyc_r, cyc_nxt;
  logic [9:0]  sec_r, sec_nxt, per;
  logic [1:0]  bm_s, bl_s, dn_s;
  logic [7:0]  temp_m_r, temp_s_r;
  logic        run;

  // two-flop synchronisers for outside inputs
  always_ff @(posedge i_sys_clk)
  begin
    bm_s     <= {bm_s[0], i_bat_mode};
    bl_s     <= {bl_s[0], i_bat_low};
    dn_s     <= {dn_s[0], i_conv_done};
    temp_m_r <= i_temp;
    temp_s_r <= temp_m_r;
  end

  // cycle permission and period choice
  always_comb
  begin
    run = regs_r.ctrl.en;
    per = PER_NORM_S;
    if (bm_s[1])
    begin
      run = run && regs_r.ctrl.bat_en && !bl_s[1];
      per = regs_r.ctrl.bat_rate ? PER_FAST_S : PER_SLOW_S;
    end
  end

  // next values of registers, scheduler and outputs
  always_comb
  begin
    regs_nxt  = regs_r;
    act_nxt   = act_r;
    fin_nxt   = fin_r;
    st_nxt    = st_r;
    start_nxt = 1'b0;
    cyc_nxt   = cyc_r;
    sec_nxt   = sec_r;
    rdata_nxt = rdata_r;
    if (i_reg_wr)
      case (i_reg_addr)
        OFS_INIT_TRIM: regs_nxt.trim = i_reg_wdata;
        OFS_CURV:      regs_nxt.curv = i_reg_wdata[6:0];
        OFS_CTRL_GAIN:
        begin
          regs_nxt.ctrl = i_reg_wdata;
          regs_nxt.ctrl.zero = 1'b0;
          if (i_reg_wdata[3:0] < GAIN_MIN)
            regs_nxt.ctrl.gain = GAIN_MIN;
          else if (i_reg_wdata[3:0] > GAIN_MAX)
            regs_nxt.ctrl.gain = GAIN_MAX;
        end
        default: ;
      endcase
    if (i_reg_rd)
      case (i_reg_addr)
        OFS_INIT_TRIM: rdata_nxt = regs_r.trim;
        OFS_CURV:      rdata_nxt = {1'b0, regs_r.curv};
        OFS_CTRL_GAIN: rdata_nxt = regs_r.ctrl;
        OFS_FIN_ANA:   rdata_nxt = {2'b00, fin_r.ana};
        OFS_FIN_DIG:   rdata_nxt = {5'b00000, fin_r.dig};
        default:       rdata_nxt = 8'h00;
      endcase
    // second tick divider and period counter
    if (cyc_r >= 32'(P_SEC_CYCLES - 1))
    begin
      cyc_nxt = 32'h0;
      sec_nxt = sec_r + 10'h001;
    end
    else
      cyc_nxt = cyc_r + 32'h1;
    if (regs_r.ctrl.en && !en_d_r)
      act_nxt = regs_r;
    case (st_r)
      S_IDLE:
        if (run && ((regs_r.ctrl.en && !en_d_r) || sec_r >= per))
        begin
          start_nxt = 1'b1;
          sec_nxt   = 10'h000;
          st_nxt    = S_WAIT;
        end
      S_WAIT:
        if (!regs_r.ctrl.en)
          st_nxt = S_IDLE;
        else if (dn_s[1])
        begin
          fin_nxt = calc(act_r, temp_s_r);
          st_nxt  = S_IDLE;
        end
      default: st_nxt = S_IDLE;
    endcase
    if (!regs_r.ctrl.en)
    begin
      fin_nxt.ana = regs_r.trim.ana;
      fin_nxt.dig = dig_map(regs_r.trim.dig);
    end
  end

  // state registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      regs_r  <= {RST_INIT_TRIM, RST_CURV, RST_CTRL_GAIN};
      act_r   <= {RST_INIT_TRIM, RST_CURV, RST_CTRL_GAIN};
      fin_r   <= '0;
      st_r    <= S_IDLE;
      start_r <= 1'b0;
      en_d_r  <= 1'b0;
      cyc_r   <= 32'h0;
      sec_r   <= 10'h000;
      rdata_r <= 8'h00;
    end
    else
    begin
      regs_r  <= regs_nxt;
      act_r   <= act_nxt;
      fin_r   <= fin_nxt;
      st_r    <= st_nxt;
      start_r <= start_nxt;
      en_d_r  <= regs_r.ctrl.en;
      cyc_r   <= cyc_nxt;
      sec_r   <= sec_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata  = rdata_r;
  assign o_conv_start = start_r;
  assign o_final      = fin_r;

  // checks, all on the system clock and quiet while reset is high
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence en_held;
    st_r == S_IDLE && regs_r.ctrl.en ##1 regs_r.ctrl.en;
  endsequence

  a_reset_off: assert property (
    $past(i_rst) |-> !regs_r.ctrl.en && !o_conv_start)
    else $error("enable not clear after reset");
  a_trim_read: assert property (
    i_reg_rd && i_reg_addr == OFS_INIT_TRIM
      |=> o_reg_rdata == $past(regs_r.trim))
    else $error("trim register readback wrong");
  a_curv_msb: assert property (
    i_reg_rd && i_reg_addr == OFS_CURV |=> !o_reg_rdata[7])
    else $error("curvature bit 7 not zero");
  a_ctrl_zero: assert property (
    i_reg_rd && i_reg_addr == OFS_CTRL_GAIN |=> !o_reg_rdata[POS_ZERO])
    else $error("control bit 4 not zero");
  a_gain_range: assert property (
    ##1 regs_r.ctrl.gain >= GAIN_MIN && regs_r.ctrl.gain <= GAIN_MAX)
    else $error("step gain outside range");
  a_off_direct: assert property (
    !regs_r.ctrl.en |=> o_final.ana == $past(regs_r.trim.ana)
      && o_final.dig == dig_map($past(regs_r.trim.dig)))
    else $error("disabled output not initial trim");
  a_snapshot: assert property (
    regs_r.ctrl.en && !en_d_r |=> act_r == $past(regs_r))
    else $error("settings not taken on enable");
  // the start flop is one edge behind the permission that raised it
  a_bat_gate: assert property (
    o_conv_start && $past(bm_s[1]) |-> $past(regs_r.ctrl.bat_en)
      && !$past(bl_s[1]))
    else $error("battery-mode cycle not allowed");
  a_start_pulse: assert property (
    o_conv_start |-> $past(regs_r.ctrl.en) ##1 !o_conv_start)
    else $error("start pulse wrong");
  a_hold_trim: assert property (
    en_held |-> $stable(o_final))
    else $error("final trim moved between cycles");
endmodule

// file: logic/tct_pkg.sv
/*
  shared constants and types of the trim and compensation control block.
  assumes an 8-bit register port and a 50 MHz system clock.
*/
package tct_pkg;
  // register offsets
  localparam logic [7:0] OFS_INIT_TRIM = 8'h0b;
  localparam logic [7:0] OFS_CURV      = 8'h0c;
  localparam logic [7:0] OFS_CTRL_GAIN = 8'h0d;
  localparam logic [7:0] OFS_FIN_ANA   = 8'h0e;
  localparam logic [7:0] OFS_FIN_DIG   = 8'h0f;
  // field positions of the control and gain register
  localparam int POS_EN      = 7;
  localparam int POS_BAT_EN  = 6;
  localparam int POS_BAT_RT  = 5;
  localparam int POS_ZERO    = 4;
  // reset values
  localparam logic [7:0] RST_INIT_TRIM = 8'h00;
  localparam logic [6:0] RST_CURV      = 7'h00;
  localparam logic [7:0] RST_CTRL_GAIN = 8'h08;
  // step gain limits, code 8 is unity
  localparam logic [3:0] GAIN_MIN = 4'h4;
  localparam logic [3:0] GAIN_MAX = 4'hc;
  // analog code of zero pull and the room temperature of the curve
  localparam int ANA_MID   = 32;
  localparam int ROOM_DEGC = 25;
  localparam int CURV_DIV  = 1024;
  // timing: second tick from the 20 ns clock, periods in seconds
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEC_NS        = 1000000000;
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  localparam logic [9:0] PER_SLOW_S = 10'd600;
  localparam logic [9:0] PER_FAST_S = 10'd60;
  localparam logic [9:0] PER_NORM_S = 10'd60;

  typedef struct packed {
    logic [1:0] dig;
    logic [5:0] ana;
  } tct_trim_t;

  typedef struct packed {
    logic       en;
    logic       bat_en;
    logic       bat_rate;
    logic       zero;
    logic [3:0] gain;
  } tct_ctrl_t;

  typedef struct packed {
    tct_trim_t  trim;
    logic [6:0] curv;
    tct_ctrl_t  ctrl;
  } tct_regs_t;

  typedef struct packed {
    logic [2:0] dig;
    logic [5:0] ana;
  } tct_final_t;
endpackage

// file: testbench/testbench.sv
/*
  self-checking bench of the trim and compensation control block.
  assumes P_SEC_CYCLES of 10 and a converter that answers promptly.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) num_checks++; if ((g) !== (e)) begin \
  $display("wrong value %s expected %h seen %h", nm, e, g); n_errors++; end
module testbench;
  import tct_pkg::*;
  logic        clk, rst, wr, rd, bat, low, done, rd_pend;
  logic [7:0]  addr, wdata, rdata, r, temp, gx;
  logic [31:0] seed;
  logic        start;
  tct_final_t  fin;
  logic [15:0] exp_q[$];
  int          n_errors, num_checks, n_start, n0;

  tct_trim_ctrl #(.P_SEC_CYCLES(10)) tct_trim_ctrl_inst (
    .i_sys_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_bat_mode(bat), .i_bat_low(low), .o_conv_start(start),
    .i_conv_done(done), .i_temp(temp), .o_final(fin));

  // clock of 20 ns
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic conclude();
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #2 wr = 1'b0;
  endtask

  // the expected byte is noted before the read is issued
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    @(posedge clk);
    #2 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #2 rd = 1'b0;
  endtask

  task automatic wait_start();
    int k;
    k = 0;
    while (n_start == n0 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  // read monitor: data is valid the cycle after the strobe
  always @(posedge clk)
  begin : mon
    logic        rd_now;
    logic [15:0] e;
    rd_now = rd;
    if (rd_pend)
    begin
      #1 e = exp_q.pop_front();
      `CHK($sformatf("register %h", e[15:8]), e[7:0], rdata)
    end
    rd_pend = rd_now;
  end

  // counts start pulses and answers each one with a done level
  always @(posedge clk)
  begin
    if (start === 1'b1)
    begin
      n_start++;
      repeat (2) @(posedge clk);
      #2 done = 1'b1;
      repeat (4) @(posedge clk);
      #2 done = 1'b0;
    end
  end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial
  begin
    {rst, wr, rd, bat, low, done, rd_pend} = 7'h40;
    {addr, wdata, n_start} = '0;
    temp = 8'h19; // room temperature, 25 degrees
    seed = 32'd82229;
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    rreg(8'h0b, 8'h00);
    rreg(8'h0d, 8'h08);
    rreg(8'h20, 8'h00);
    seed = xs(seed);
    r = seed[7:0];
    wreg(8'h0b, r);
    rreg(8'h0b, r);
    rreg(8'h0e, {2'b0, r[5:0]});
    `CHK("final analog", r[5:0], fin.ana)
    wreg(8'h0e, 8'hff);
    rreg(8'h0e, {2'b0, r[5:0]});
    wreg(8'h0c, seed[15:8] | 8'h80);
    rreg(8'h0c, {1'b0, seed[14:8]});
    // every gain code, with bit 4 set on the way in
    for (int g = 0; g < 16; g++)
    begin
      wreg(8'h0d, 8'h70 | 8'(g));
      gx = (g < 4) ? 8'h04 : ((g > 12) ? 8'h0c : 8'(g));
      rreg(8'h0d, 8'h60 | gx);
    end
    // compensation at room temperature, gain code 4, double step
    wreg(8'h0b, 8'h9e);
    wreg(8'h0d, 8'h84);
    n0 = n_start;
    wait_start();
    `CHK("start count", n0 + 1, n_start)
    repeat (10) @(posedge clk);
    rreg(8'h0e, 8'h1c);
    rreg(8'h0f, 8'h00);
    repeat (40) @(posedge clk);
    rreg(8'h0e, 8'h1c);
    wreg(8'h0d, 8'h04);
    rreg(8'h0e, 8'h1e);
    wreg(8'h0b, 8'h9d);
    wreg(8'h0d, 8'h84);
    repeat (14) @(posedge clk);
    rreg(8'h0e, 8'h1a);
    // hot crystal, curvature 35, gain rewritten around the enable
    wreg(8'h0d, 8'h04);
    wreg(8'h0c, 8'h23);
    temp = 8'h4b;
    wreg(8'h0d, 8'h08);
    wreg(8'h0d, 8'h88);
    repeat (14) @(posedge clk);
    rreg(8'h0e, 8'h08);
    rreg(8'h0f, 8'h02);
    `CHK("final digital", 3'h2, fin.dig)
    // battery mode: low supply, then battery enable off, then battery enable on
    wreg(8'h0d, 8'h04);
    bat = 1'b1;
    low = 1'b1;
    n0 = n_start;
    wreg(8'h0d, 8'hc4);
    repeat (50) @(posedge clk);
    `CHK("start count", n0, n_start)
    wreg(8'h0d, 8'h44);
    low = 1'b0;
    wreg(8'h0d, 8'h84);
    repeat (50) @(posedge clk);
    `CHK("start count", n0, n_start)
    wreg(8'h0d, 8'h04);
    wreg(8'h0d, 8'he4);
    wait_start();
    `CHK("start count", n0 + 1, n_start)
    repeat (570) @(posedge clk);
    `CHK("start count", n0 + 1, n_start)
    repeat (60) @(posedge clk);
    `CHK("start count", n0 + 2, n_start)
    wreg(8'h0d, 8'h04);
    n0 = n_start;
    wreg(8'h0d, 8'hc4);
    repeat (1300) @(posedge clk);
    `CHK("start count", n0 + 1, n_start)
    repeat (4680) @(posedge clk);
    `CHK("start count", n0 + 1, n_start)
    repeat (40) @(posedge clk);
    `CHK("start count", n0 + 2, n_start)
    // second reset in mid-run
    #2 rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    rreg(8'h0d, 8'h08);
    rreg(8'h0e, 8'h00);
    conclude();
  end
endmodule
